// ===== src/usart_cfg_pkg.sv
// Notes on behaviour
// - Transmitter appends computed parity when enabled.
// - Receiver checks parity, flags any mismatch.
// - Parity codes: off, reserved, even, odd.
// - Stop select: one or two stop bits.
// - Receiver ignores the stop select.
// - Size codes give 5-8 bits, 111 nine.
// - Sync polarity picks shift and sample edges.
// - Clear-to-send enable gates transmit start.
// - Request-to-send rises when receive FIFO full and its enable is set.
// - Flow register bits 7:2 read zero.
// - Divisor is 12 bits over two bytes.
// - Low byte write reloads the prescaler.
// - Double speed cuts oversampling 16 to 8.
// - Mode 00 async, 01 synchronous.
`default_nettype none
package usart_cfg_pkg;
    localparam int ADR_W = 5;
    localparam logic [4:0] OFF_DATA     = 5'h00;
    localparam logic [4:0] OFF_STATUS   = 5'h04;
    localparam logic [4:0] OFF_CTRL_B   = 5'h08;
    localparam logic [4:0] OFF_FRAME    = 5'h0C;
    localparam logic [4:0] OFF_FLOW     = 5'h10;
    localparam logic [4:0] OFF_DIV_LOW  = 5'h14;
    localparam logic [4:0] OFF_DIV_HIGH = 5'h18;

    localparam int ST_DBL  = 1;
    localparam int ST_PERR = 2;
    localparam int ST_TXE  = 5;
    localparam int ST_IDLE = 6;
    localparam int ST_RXC  = 7;

    localparam int CB_TXB8 = 0;
    localparam int CB_RXB8 = 1;
    localparam int CB_SZHI = 2;
    localparam int CB_TXEN = 3;
    localparam int CB_RXEN = 4;

    localparam int FF_POL  = 0;
    localparam int FF_SZLO = 1;
    localparam int FF_STOP = 3;
    localparam int FF_PAR  = 4;
    localparam int FF_MODE = 6;

    localparam int FL_RTS = 0;
    localparam int FL_CTS = 1;

    localparam logic [7:0]  FRAME_RST  = 8'h06;
    localparam logic [1:0]  FLOW_RST   = 2'h0;
    localparam logic [11:0] DIV_RST    = 12'h000;
    localparam logic [3:0]  DIV_HI_MSK = 4'hF;

    localparam logic [4:0] OS_NORMAL = 5'h10;
    localparam logic [4:0] OS_DOUBLE = 5'h08;

    localparam int FIFO_DEPTH = 4;

    typedef enum logic [1:0] {
        PAR_OFF  = 2'b00,
        PAR_RSVD = 2'b01,
        PAR_EVEN = 2'b10,
        PAR_ODD  = 2'b11
    } parity_t;

    typedef enum logic [1:0] {
        MODE_ASYNC = 2'b00,
        MODE_SYNC  = 2'b01
    } mode_t;
endpackage
`default_nettype wire

// ===== src/usart_rx_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module usart_rx_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic             flush,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData,
    output logic                  full
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0] DEPTH_C = (PW + 1)'(DEPTH);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

    logic [WIDTH-1:0] memQ [DEPTH];
    logic [PW-1:0]    wrPtrQ;
    logic [PW-1:0]    rdPtrQ;
    logic [PW:0]      countQ;

    wire push = inValid && inReady;
    wire pop  = outValid && outReady;

    assign full     = (countQ == DEPTH_C);
    assign inReady  = !full && !flush;
    assign outValid = (countQ != '0);
    assign outData  = memQ[rdPtrQ];

    always_ff @(posedge clk) begin
        if (push) begin
            memQ[wrPtrQ] <= inData;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wrPtrQ <= '0;
            rdPtrQ <= '0;
            countQ <= '0;
        end else if (flush) begin
            wrPtrQ <= '0;
            rdPtrQ <= '0;
            countQ <= '0;
        end else begin
            if (push) begin
                wrPtrQ <= (wrPtrQ == LAST) ? '0 : wrPtrQ + 1'b1;
            end
            if (pop) begin
                rdPtrQ <= (rdPtrQ == LAST) ? '0 : rdPtrQ + 1'b1;
            end
            countQ <= countQ + (PW + 1)'(push) - (PW + 1)'(pop);
        end
    end
endmodule
`default_nettype wire

// ===== src/usart_frame_flow_baud_config.sv
// The implementer's own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
module usart_frame_flow_baud_config #(
    parameter int FIFO_DEPTH = usart_cfg_pkg::FIFO_DEPTH
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [4:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        serialInPin,
    output logic             serialOutPin,
    output logic             syncClockPinOut,
    output logic             syncClockPinOe,
    input  wire logic        clearToSendN,
    output logic             requestToSendN
);
    typedef enum logic [2:0] {
        TX_IDLE   = 3'b000,
        TX_START  = 3'b001,
        TX_DATA   = 3'b010,
        TX_PARITY = 3'b011,
        TX_STOP   = 3'b100
    } tx_state_t;

    typedef enum logic [1:0] {
        RX_IDLE   = 2'b00,
        RX_START  = 2'b01,
        RX_DATA   = 2'b10,
        RX_PARITY = 2'b11
    } rx_state_t;

    // Data bits from the size code; reserved codes fall back to eight
    function automatic logic [3:0] charBits(input logic [2:0] code);
        unique case (code)
            3'b000:  charBits = 4'h5;
            3'b001:  charBits = 4'h6;
            3'b010:  charBits = 4'h7;
            3'b111:  charBits = 4'h9;
            default: charBits = 4'h8;
        endcase
    endfunction

    function automatic logic parityOf(input logic [8:0] d,
                                      input logic [3:0] n,
                                      input logic       odd);
        logic acc;
        acc = odd;
        for (int i = 0; i < 9; i++) begin
            if (4'(i) < n) begin
                acc = acc ^ d[i];
            end
        end
        parityOf = acc;
    endfunction

    // Register state
    logic        ackQ;
    logic [31:0] rdDatQ;
    logic [7:0]  frameQ;
    logic [1:0]  flowQ;
    logic [11:0] baudDivisorQ;
    logic        dblQ;
    logic        rxEnQ;
    logic        txEnQ;
    logic        sizeHiQ;
    logic        txB8Q;
    logic [8:0]  txHoldQ;
    logic        txHoldFullQ;

    // Baud and link state
    logic [11:0] baudCntQ;
    logic        xckQ;
    logic [3:0]  txOsQ;
    logic [3:0]  rxOsQ;
    tx_state_t   txState;
    rx_state_t   rxState;
    logic [8:0]  txShiftQ;
    logic [3:0]  txCntQ;
    logic        txParQ;
    logic        stopCntQ;
    logic        serialOutQ;
    logic        rxPrevQ;
    logic [8:0]  rxShiftQ;
    logic [3:0]  rxCntQ;
    logic        rxParBitQ;

    // FIFO wires
    logic        fifoInReady;
    logic        fifoOutValid;
    logic [9:0]  fifoOutData;
    logic        fifoFull;

    // Bus decode
    wire req     = wb_cyc_i && wb_stb_i;
    wire wrEn    = req && wb_we_i && ackQ && wb_sel_i[0];
    wire rdTake  = req && !wb_we_i && ackQ;
    wire adData  = (wb_adr_i == usart_cfg_pkg::OFF_DATA);
    wire adStat  = (wb_adr_i == usart_cfg_pkg::OFF_STATUS);
    wire adCtrlB = (wb_adr_i == usart_cfg_pkg::OFF_CTRL_B);
    wire adFrame = (wb_adr_i == usart_cfg_pkg::OFF_FRAME);
    wire adFlow  = (wb_adr_i == usart_cfg_pkg::OFF_FLOW);
    wire adDivLo = (wb_adr_i == usart_cfg_pkg::OFF_DIV_LOW);
    wire adDivHi = (wb_adr_i == usart_cfg_pkg::OFF_DIV_HIGH);
    wire lowWr   = wrEn && adDivLo;
    wire dataWr  = wrEn && adData;
    wire popRx   = rdTake && adData;

    // Frame configuration fields
    wire [1:0] parMode = frameQ[usart_cfg_pkg::FF_PAR +: 2];
    wire parEn = (parMode == usart_cfg_pkg::PAR_EVEN)
              || (parMode == usart_cfg_pkg::PAR_ODD);
    wire parOdd = (parMode == usart_cfg_pkg::PAR_ODD);
    wire stopSel = frameQ[usart_cfg_pkg::FF_STOP];
    wire pol = frameQ[usart_cfg_pkg::FF_POL];
    wire syncMode = (frameQ[usart_cfg_pkg::FF_MODE +: 2]
                  == usart_cfg_pkg::MODE_SYNC);
    wire [3:0] nBits = charBits({sizeHiQ,
                       frameQ[usart_cfg_pkg::FF_SZLO +: 2]});
    wire clear_to_send_en = flowQ[usart_cfg_pkg::FL_CTS];
    wire request_to_send_en = flowQ[usart_cfg_pkg::FL_RTS];

    // Oversampling period and mid-bit point
    wire [4:0] osLen = dblQ ? usart_cfg_pkg::OS_DOUBLE
                            : usart_cfg_pkg::OS_NORMAL;
    wire [3:0] osLast = 4'(osLen - 5'h01);
    wire [3:0] osHalf = 4'((osLen >> 1) - 5'h01);

    wire baudTick = (baudCntQ == 12'h000);
    wire syncTxEdge = syncMode && baudTick && (pol ? xckQ : !xckQ);
    wire syncRxEdge = syncMode && baudTick && (pol ? !xckQ : xckQ);
    wire txStep = syncMode ? syncTxEdge
                           : (baudTick && txOsQ == osLast);
    wire rxSample = syncMode ? syncRxEdge
                             : (baudTick && rxOsQ == osHalf);
    wire ctsOk = !clear_to_send_en || !clearToSendN;
    wire txStart = (txState == TX_IDLE) && txHoldFullQ && txEnQ && ctsOk
                && (syncMode ? syncTxEdge : 1'b1);
    wire rxFall = !syncMode && rxPrevQ && !serialInPin;
    wire rxDone = (rxState == RX_DATA || rxState == RX_PARITY) && rxSample
               && (rxState == RX_PARITY
               || (rxCntQ == nBits - 4'h1 && !parEn));
    wire rxPerr = parEn
               && (rxParBitQ != parityOf(rxShiftQ, nBits, parOdd));
    logic rxDoneQ;
    wire rxStopSample = (rxState == RX_IDLE) && rxDoneQ;
    wire [9:0] rxWord = {rxPerr, rxShiftQ};

    assign requestToSendN = request_to_send_en && fifoFull;
    assign serialOutPin = serialOutQ;
    assign syncClockPinOut = xckQ;
    assign syncClockPinOe = syncMode;
    assign wb_ack_o = ackQ;
    assign wb_dat_o = rdDatQ;

    // Read mux
    wire [7:0] statRd = {fifoOutValid,
                         (txState == TX_IDLE) && !txHoldFullQ,
                         !txHoldFullQ, 2'b00, fifoOutData[9], dblQ, 1'b0};
    wire [7:0] ctrlRd = {3'b000, rxEnQ, txEnQ, sizeHiQ,
                         fifoOutData[8], txB8Q};
    wire [7:0] rdMux =
        adData  ? fifoOutData[7:0] :
        adStat  ? statRd :
        adCtrlB ? ctrlRd :
        adFrame ? frameQ :
        adFlow  ? {6'h00, flowQ} :
        adDivLo ? baudDivisorQ[7:0] :
        adDivHi ? {4'h0, baudDivisorQ[11:8]} : 8'h00;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ackQ   <= 1'b0;
            rdDatQ <= 32'h0000_0000;
        end else begin
            ackQ   <= req && !ackQ;
            rdDatQ <= {24'h00_0000, rdMux};
        end
    end

    // Software-written registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            frameQ       <= usart_cfg_pkg::FRAME_RST;
            flowQ        <= usart_cfg_pkg::FLOW_RST;
            baudDivisorQ <= usart_cfg_pkg::DIV_RST;
            dblQ         <= 1'b0;
            {rxEnQ, txEnQ, sizeHiQ, txB8Q} <= 4'h0;
        end else if (wrEn) begin
            if (adFrame) frameQ <= wb_dat_i[7:0];
            if (adFlow) flowQ <= wb_dat_i[1:0];
            if (adStat) dblQ <= wb_dat_i[usart_cfg_pkg::ST_DBL];
            if (adCtrlB) begin
                rxEnQ   <= wb_dat_i[usart_cfg_pkg::CB_RXEN];
                txEnQ   <= wb_dat_i[usart_cfg_pkg::CB_TXEN];
                sizeHiQ <= wb_dat_i[usart_cfg_pkg::CB_SZHI];
                txB8Q   <= wb_dat_i[usart_cfg_pkg::CB_TXB8];
            end
            if (adDivLo) baudDivisorQ[7:0] <= wb_dat_i[7:0];
            if (adDivHi) begin
                baudDivisorQ[11:8] <= wb_dat_i[3:0]
                                    & usart_cfg_pkg::DIV_HI_MSK;
            end
        end
    end

    // Transmit holding register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            txHoldQ     <= 9'h000;
            txHoldFullQ <= 1'b0;
        end else if (dataWr) begin
            txHoldQ     <= {txB8Q, wb_dat_i[7:0]};
            txHoldFullQ <= 1'b1;
        end else if (txStart) begin
            txHoldFullQ <= 1'b0;
        end
    end

    // Prescaler: low byte write reloads with the new full divisor
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            baudCntQ <= usart_cfg_pkg::DIV_RST;
            xckQ     <= 1'b0;
        end else begin
            if (lowWr) begin
                baudCntQ <= {baudDivisorQ[11:8], wb_dat_i[7:0]};
            end else if (baudTick) begin
                baudCntQ <= baudDivisorQ;
            end else begin
                baudCntQ <= baudCntQ - 12'h001;
            end
            if (!syncMode) begin
                xckQ <= 1'b0;
            end else if (baudTick) begin
                xckQ <= !xckQ;
            end
        end
    end

    // Oversampling phase counters
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            txOsQ <= 4'h0;
            rxOsQ <= 4'h0;
        end else begin
            if (txStart) txOsQ <= 4'h0;
            else if (baudTick) txOsQ <= (txOsQ == osLast) ? 4'h0 : txOsQ + 4'h1;
            if (rxState == RX_IDLE && rxFall) rxOsQ <= 4'h0;
            else if (baudTick) rxOsQ <= (rxOsQ == osLast) ? 4'h0 : rxOsQ + 4'h1;
        end
    end

    // Transmit frame sequencer
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            txState    <= TX_IDLE;
            txShiftQ   <= 9'h000;
            txCntQ     <= 4'h0;
            txParQ     <= 1'b0;
            stopCntQ   <= 1'b0;
            serialOutQ <= 1'b1;
        end else if (txStart) begin
            txState    <= TX_START;
            txShiftQ   <= txHoldQ;
            txParQ     <= parityOf(txHoldQ, nBits, parOdd);
            txCntQ     <= 4'h0;
            serialOutQ <= 1'b0;
        end else if (txStep) begin
            unique case (txState)
                TX_IDLE: serialOutQ <= 1'b1;
                TX_START, TX_DATA: begin
                    if (txState == TX_DATA && txCntQ == nBits) begin
                        txState    <= parEn ? TX_PARITY : TX_STOP;
                        serialOutQ <= parEn ? txParQ : 1'b1;
                        stopCntQ   <= stopSel;
                    end else begin
                        txState    <= TX_DATA;
                        serialOutQ <= txShiftQ[0];
                        txShiftQ   <= txShiftQ >> 1;
                        txCntQ     <= txCntQ + 4'h1;
                    end
                end
                TX_PARITY: begin
                    txState    <= TX_STOP;
                    serialOutQ <= 1'b1;
                end
                TX_STOP: begin
                    if (stopCntQ) stopCntQ <= 1'b0;
                    else txState <= TX_IDLE;
                end
                default: txState <= TX_IDLE;
            endcase
        end
    end

    // Receive frame sequencer; no stop bit is sampled or checked, regardless of select
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rxState   <= RX_IDLE;
            rxPrevQ   <= 1'b1;
            rxShiftQ  <= 9'h000;
            rxCntQ    <= 4'h0;
            rxParBitQ <= 1'b0;
            rxDoneQ   <= 1'b0;
        end else begin
            rxPrevQ <= serialInPin;
            rxDoneQ <= rxDone;
            if (!rxEnQ) begin
                rxState <= RX_IDLE;
            end else begin
                unique case (rxState)
                    RX_IDLE: begin
                        if (rxFall) begin
                            rxState <= RX_START;
                        end else if (syncRxEdge && !serialInPin) begin
                            rxState  <= RX_DATA;
                            rxShiftQ <= 9'h000;
                            rxCntQ   <= 4'h0;
                        end
                    end
                    RX_START: begin
                        if (rxSample) begin
                            rxState  <= serialInPin ? RX_IDLE : RX_DATA;
                            rxShiftQ <= 9'h000;
                            rxCntQ   <= 4'h0;
                        end
                    end
                    RX_DATA: begin
                        if (rxSample) begin
                            rxShiftQ[rxCntQ] <= serialInPin;
                            rxCntQ <= rxCntQ + 4'h1;
                            if (rxCntQ == nBits - 4'h1) begin
                                rxState <= parEn ? RX_PARITY : RX_IDLE;
                            end
                        end
                    end
                    RX_PARITY: begin
                        if (rxSample) begin
                            rxParBitQ <= serialInPin;
                            rxState   <= RX_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // Completed characters queue here; a full queue drops the new one
    usart_rx_fifo #(
        .WIDTH (10),
        .DEPTH (FIFO_DEPTH)
    ) rxFifo (
        .clk      (clk),
        .arst_n   (arst_n),
        .flush    (!rxEnQ),
        .inValid  (rxStopSample),
        .inReady  (fifoInReady),
        .inData   (rxWord),
        .outValid (fifoOutValid),
        .outReady (popRx),
        .outData  (fifoOutData),
        .full     (fifoFull)
    );

    // Marks that the first step in the stop state has been taken
    logic stopStepQ;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stopStepQ <= 1'b0;
        end else if (txState != TX_STOP) begin
            stopStepQ <= 1'b0;
        end else if (txStep) begin
            stopStepQ <= 1'b1;
        end
    end

    sequence s_firstStopStep;
        txState == TX_STOP && txStep && !stopStepQ;
    endsequence

    sequence s_lowWrite;
        lowWr;
    endsequence

    sequence s_ctsHeld;
        (txState == TX_IDLE) && clear_to_send_en && clearToSendN;
    endsequence

    property p_reload;
        @(posedge clk) disable iff (!arst_n)
        s_lowWrite |=> baudCntQ == baudDivisorQ;
    endproperty
    a_reload: assert property (p_reload)
        else $error("Low byte write did not reload prescaler");

    property p_tickPeriod;
        @(posedge clk) disable iff (!arst_n)
        baudTick && !lowWr && !(wrEn && adDivHi)
            |=> baudCntQ == baudDivisorQ;
    endproperty
    a_tickPeriod: assert property (p_tickPeriod)
        else $error("Prescaler did not restart from divisor");

    property p_osAsync;
        @(posedge clk) disable iff (!arst_n)
        !syncMode && txStep |-> baudTick && txOsQ == (dblQ ? 4'h7 : 4'hF);
    endproperty
    a_osAsync: assert property (p_osAsync)
        else $error("Async bit step not on oversample boundary");

    property p_cts;
        @(posedge clk) disable iff (!arst_n)
        s_ctsHeld |=> txState == TX_IDLE;
    endproperty
    a_cts: assert property (p_cts)
        else $error("Transmit began while clear-to-send was high");

    property p_rts;
        @(posedge clk) disable iff (!arst_n)
        requestToSendN == (request_to_send_en && fifoFull);
    endproperty
    a_rts: assert property (p_rts)
        else $error("Request-to-send does not follow FIFO full");

    property p_stopTwo;
        @(posedge clk) disable iff (!arst_n)
        s_firstStopStep ##0 stopSel |=> txState == TX_STOP;
    endproperty
    a_stopTwo: assert property (p_stopTwo)
        else $error("Second stop bit missing");

    property p_stopOne;
        @(posedge clk) disable iff (!arst_n)
        s_firstStopStep ##0 !stopSel |=> txState == TX_IDLE;
    endproperty
    a_stopOne: assert property (p_stopOne)
        else $error("Extra stop bit with single stop selected");

    property p_txParity;
        @(posedge clk) disable iff (!arst_n)
        txState == TX_PARITY |-> serialOutQ == txParQ;
    endproperty
    a_txParity: assert property (p_txParity)
        else $error("Parity bit on line differs from computed");

    property p_perr;
        @(posedge clk) disable iff (!arst_n)
        rxStopSample |-> rxWord[9]
            == (parEn && (^rxShiftQ ^ rxParBitQ ^ parOdd));
    endproperty
    a_perr: assert property (p_perr)
        else $error("Stored parity error differs from recomputed");

    property p_flowRsvd;
        @(posedge clk) disable iff (!arst_n)
        ackQ && !wb_we_i && adFlow |-> wb_dat_o[7:2] == 6'h00;
    endproperty
    a_flowRsvd: assert property (p_flowRsvd)
        else $error("Flow register reserved bits read nonzero");

    property p_syncEdge;
        @(posedge clk) disable iff (!arst_n)
        syncMode && $stable(frameQ) && $changed(serialOutQ) |-> xckQ != pol;
    endproperty
    a_syncEdge: assert property (p_syncEdge)
        else $error("Sync data changed on the wrong clock edge");
endmodule
`default_nettype wire

// ===== dv/usart_peer.sv
`timescale 1ns/10ps
`default_nettype none
module usart_peer (
    input  wire logic clk,
    input  wire logic sclk,
    input  wire logic txLine,
    output logic      rxLine
);
    initial rxLine = 1'b1;
    // Start bit, then n bits LSB first; the last bit must be a stop
    task automatic send(input logic [11:0] b, input int n, input int bitClk);
        int i;
        @(posedge clk);
        rxLine <= 1'b0;
        repeat (bitClk) @(posedge clk);
        for (i = 0; i < n; i++) begin
            rxLine <= b[i];
            repeat (bitClk) @(posedge clk);
        end
    endtask
    // Synchronous frame: each bit taken at the edge where sclk equals pol
    task automatic grabSync(input logic pol, output logic [11:0] b);
        int i;
        do @(sclk); while (sclk !== pol || txLine !== 1'b0);
        for (i = 0; i < 12; i++) begin
            do @(sclk); while (sclk !== pol);
            b[i] = txLine;
        end
    endtask
    // Samples 12 bits after the start bit at bit centres
    task automatic grab(input int bitClk, output logic [11:0] b);
        int i;
        do @(negedge clk); while (txLine !== 1'b0);
        repeat (bitClk / 2) @(negedge clk);
        for (i = 0; i < 12; i++) begin
            repeat (bitClk) @(negedge clk);
            b[i] = txLine;
        end
    endtask
endmodule
`default_nettype wire

// ===== dv/usart_frame_flow_baud_config_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin samplesChecked++; if ((s) !== (e)) begin \
    errCount++; $display("mismatch %0s exp %h got %h", n, e, s); end end
module usart_frame_flow_baud_config_tb;
    logic        clk = 1'b0;
    logic        arstN = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [4:0]  adr = 5'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        ack, txLine, sclk, sclkOe, rtsN, rxLine, hold;
    logic        ctsN = 1'b0;
    logic [7:0]  q;
    logic [11:0] got;
    int          errCount = 0;
    int          samplesChecked = 0;
    logic [2:0]  szT [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h3};
    logic [1:0]  parT [6] = '{2'h2, 2'h3, 2'h0, 2'h2, 2'h3, 2'h0};
    logic [8:0]  datT [6] = '{9'h013, 9'h02A, 9'h055, 9'h0A5, 9'h1C3, 9'h070};
    int          nT [6] = '{5, 6, 7, 8, 9, 8};

    usart_frame_flow_baud_config u_dut (.clk(clk), .arst_n(arstN),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .serialInPin(rxLine), .serialOutPin(txLine),
        .syncClockPinOut(sclk), .syncClockPinOe(sclkOe),
        .clearToSendN(ctsN), .requestToSendN(rtsN));
    usart_peer u_peer (.clk(clk), .sclk(sclk), .txLine(txLine),
        .rxLine(rxLine));

    initial forever #20 clk = ~clk;

    task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(negedge clk);
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e, input string n);
        wb(1'b0, a, 8'h00);
        `CHK(n, e, q)
    endtask
    // Expected bits after the start bit: data, parity, then idle ones
    function automatic logic [11:0] frm(input logic [8:0] d, input int n,
                                        input logic [1:0] par);
        logic [11:0] f;
        logic        p;
        f = 12'hFFF;
        p = par[0];
        for (int i = 0; i < n; i++) begin
            f[i] = d[i];
            p ^= d[i];
        end
        if (par[1]) f[n] = p;
        return f;
    endfunction
    task automatic txCase(input logic [2:0] sz, input logic [1:0] par,
                          input logic st, input logic [8:0] d, input int bc,
                          input int n);
        wb(1'b1, usart_cfg_pkg::OFF_FRAME, {2'h0, par, st, sz[1:0], 1'b0});
        wb(1'b1, usart_cfg_pkg::OFF_CTRL_B, {5'h03, sz[2], 1'b0, d[8]});
        wb(1'b1, usart_cfg_pkg::OFF_DATA, d[7:0]);
        u_peer.grab(bc, got);
        `CHK("txFrame", frm(d, n, par), got)
        repeat (bc) @(posedge clk);
    endtask
    task automatic endOfTest;
        $display("checks %0d mismatches %0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        errCount++;
        endOfTest;
    end

    initial begin
        repeat (16) @(posedge clk);
        arstN <= 1'b1;
        rd(usart_cfg_pkg::OFF_FRAME, 8'h06, "frameRst");
        rd(usart_cfg_pkg::OFF_FLOW, 8'h00, "flowRst");
        wb(1'b1, 5'h1C, 8'hFF);
        rd(5'h1C, 8'h00, "unmapped");
        wb(1'b1, usart_cfg_pkg::OFF_FLOW, 8'h03);
        rd(usart_cfg_pkg::OFF_FLOW, 8'h03, "flow");
        wb(1'b1, usart_cfg_pkg::OFF_DIV_HIGH, 8'h00);
        wb(1'b1, usart_cfg_pkg::OFF_DIV_LOW, 8'h01);
        rd(usart_cfg_pkg::OFF_DIV_LOW, 8'h01, "divLow");
        wb(1'b1, usart_cfg_pkg::OFF_FRAME, 8'h46);
        `CHK("syncOe", 1'b1, sclkOe)
        wb(1'b1, usart_cfg_pkg::OFF_FRAME, 8'h06);
        `CHK("asyncOe", 1'b0, sclkOe)
        $display("test registers done");
        @(posedge clk);
        ctsN <= 1'b1;
        wb(1'b1, usart_cfg_pkg::OFF_CTRL_B, 8'h18);
        wb(1'b1, usart_cfg_pkg::OFF_DATA, 8'h3C);
        hold = 1'b1;
        repeat (64) @(negedge clk) if (txLine !== 1'b1) hold = 1'b0;
        `CHK("ctsHold", 1'b1, hold)
        @(posedge clk);
        ctsN <= 1'b0;
        u_peer.grab(32, got);
        `CHK("ctsFrame", frm(9'h03C, 8, 2'h0), got)
        repeat (32) @(posedge clk);
        for (int p = 0; p < 2; p++) begin
            wb(1'b1, usart_cfg_pkg::OFF_FRAME, {7'h23, p[0]});
            wb(1'b1, usart_cfg_pkg::OFF_DATA, 8'hB4 ^ 8'(p));
            u_peer.grabSync(p[0], got);
            `CHK("syncFrame", frm(9'h0B4 ^ 9'(p), 8, 2'h0), got)
        end
        for (int i = 0; i < 6; i++)
            txCase(szT[i], parT[i], i[0], datT[i], 32, nT[i]);
        wb(1'b1, usart_cfg_pkg::OFF_STATUS, 8'h02);
        txCase(3'h3, 2'h2, 1'b0, 9'h0E1, 16, 8);
        $display("test transmit done");
        wb(1'b1, usart_cfg_pkg::OFF_FRAME, 8'h2E);
        for (int i = 0; i < 4; i++)
            u_peer.send(frm(9'h040 + 9'(i), 8, 2'h2)
                        ^ ((i == 0) ? 12'h100 : 12'h000), 10, 16);
        repeat (8) @(negedge clk);
        `CHK("rtsFull", 1'b1, rtsN)
        rd(usart_cfg_pkg::OFF_STATUS, 8'hE6, "statusBad");
        rd(usart_cfg_pkg::OFF_DATA, 8'h40, "rxData");
        `CHK("rtsFree", 1'b0, rtsN)
        rd(usart_cfg_pkg::OFF_STATUS, 8'hE2, "statusGood");
        rd(usart_cfg_pkg::OFF_DATA, 8'h41, "rxData");
        $display("test receive done");
        endOfTest;
    end
endmodule
`default_nettype wire
